// >>> inc/metering_config_params.svh
// Purpose: Addresses, field positions, defaults and counts of the metering configuration bank.
// Assumes: Included by every file of the bank; definitions only.
`ifndef METERING_CONFIG_PARAMS_SVH
`define METERING_CONFIG_PARAMS_SVH

`define SAMPLE_W 24
`define CFG_ADDR 16'hE618
`define MODE_ADDR 16'hE700
`define CFG_INTEG 0
`define CFG_SWAP 3
`define CFG_VGND 4
`define CFG_IGND 5
`define CFG_FAST 6
`define CFG_SOFT_RST 7
`define CFG_VA_LSB 8
`define CFG_VB_LSB 10
`define CFG_VC_LSB 12
`define CFG_WMASK 16'h3FF9
`define CFG_DEFAULT 16'h0000
`define MM_PER_LSB 0
`define MM_PEAK_LSB 2
`define MM_WMASK 8'h1F
`define MM_DEFAULT 8'h1C
`define SEL_RESERVED 2'h3
`define PHASE_A 2'h0
`define PHASE_B 2'h1
`define PHASE_C 2'h2
`define SOFT_RESET_TRIGGER_CYCLES 4'h4

`endif

// >>> inc/metering_config_pkg.sv
// Purpose: Types shared by the metering configuration bank.
// Assumes: Widths come from metering_config_params.svh.
// Notes: None.
`include "metering_config_params.svh"
package metering_config_pkg;

    typedef struct packed {
        logic [`SAMPLE_W-1:0] a;
        logic [`SAMPLE_W-1:0] b;
        logic [`SAMPLE_W-1:0] c;
    } phase3_type;

    typedef enum logic [0:0] {
        RST_IDLE = 1'b0,
        RST_ACTIVE = 1'b1
    } soft_reset_state_type;

endpackage

// >>> design/phase_voltage_mux.sv
// Purpose: Picks one phase voltage from a select code counted from a base phase.
// Assumes: Code 11 behaves as 00.
// Notes: Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`include "metering_config_params.svh"
module phase_voltage_mux
    import metering_config_pkg::*;
(
    // Selection
    input wire logic [1:0] code,
    input wire logic [1:0] base,
    // Voltages
    input wire phase3_type volts,
    output logic [`SAMPLE_W-1:0] chosen
);

    logic [1:0] eff;
    logic [2:0] sum;

    always_comb begin
        eff = (code == `SEL_RESERVED) ? `PHASE_A : code;
        sum = {1'b0, base} + {1'b0, eff};
        case (sum)
            3'h0, 3'h3: chosen = volts.a;
            3'h1, 3'h4: chosen = volts.b;
            3'h2: chosen = volts.c;
            default: chosen = volts.a;
        endcase
    end

endmodule

// >>> design/metering_config_select.sv
// Purpose: Configuration and measurement-mode registers and the selection logic they steer.
// Assumes: Register port and all data inputs come from logic on clk_sys.
// Notes: Read data appears one cycle after a read strobe; writes outside a software reset take effect next edge.
`timescale 1ns/1ps
`include "metering_config_params.svh"
module metering_config_select
    import metering_config_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Register port
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata_r,
    output logic reg_rvalid_r,
    // Converter samples
    input wire phase3_type voltage_raw,
    input wire phase3_type current_raw,
    input wire phase3_type current_int,
    input wire logic [`SAMPLE_W-1:0] neutral_raw,
    input wire logic [`SAMPLE_W-1:0] neutral_int,
    // Channel outputs
    output phase3_type voltage_out_r,
    output phase3_type current_out_r,
    output logic [`SAMPLE_W-1:0] neutral_out_r,
    output phase3_type power_voltage_r,
    output logic [`SAMPLE_W-1:0] period_voltage_r,
    // Peak window
    input wire logic [2:0] zero_cross,
    input wire logic [7:0] peak_window_cycles,
    output logic [2:0] peak_phase_enables_r,
    output logic peak_window_done_r,
    // Shared pin and reset
    input wire logic energy_pulse,
    input wire logic fast_capture_clock,
    output logic third_pulse_pin_r,
    output logic fast_capture_port_enable_r,
    output logic soft_reset_r
);

    // ----------------------------------------
    // Registers and software reset
    // ----------------------------------------
    logic [15:0] cfg_r;
    logic [15:0] cfg_nxt;
    logic [7:0] mode_r;
    logic [7:0] mode_nxt;
    soft_reset_state_type rst_state_r;
    soft_reset_state_type rst_state_nxt;
    logic [3:0] rst_cnt_r;
    logic [3:0] rst_cnt_nxt;
    logic [15:0] rdata_nxt;
    logic soft_reset_nxt;

    always_comb begin
        cfg_nxt = cfg_r;
        mode_nxt = mode_r;
        rst_state_nxt = rst_state_r;
        rst_cnt_nxt = rst_cnt_r;
        case (rst_state_r)
            RST_IDLE: begin
                if (reg_wr && reg_addr == `CFG_ADDR) begin
                    cfg_nxt = reg_wdata & `CFG_WMASK;
                    if (reg_wdata[`CFG_SOFT_RST]) begin
                        rst_state_nxt = RST_ACTIVE;
                        rst_cnt_nxt = `SOFT_RESET_TRIGGER_CYCLES;
                    end
                end else if (reg_wr && reg_addr == `MODE_ADDR) begin
                    mode_nxt = reg_wdata[7:0] & `MM_WMASK;
                end
            end
            RST_ACTIVE: begin
                rst_cnt_nxt = rst_cnt_r - 4'h1;
                if (rst_cnt_r == 4'h1) begin
                    rst_state_nxt = RST_IDLE;
                    cfg_nxt = `CFG_DEFAULT;
                    mode_nxt = `MM_DEFAULT;
                end
            end
            default: begin
                rst_state_nxt = RST_IDLE;
            end
        endcase
        soft_reset_nxt = (rst_state_nxt == RST_ACTIVE);
        if (reg_addr == `CFG_ADDR) begin
            rdata_nxt = cfg_r;
        end else if (reg_addr == `MODE_ADDR) begin
            rdata_nxt = {8'h00, mode_r};
        end else begin
            rdata_nxt = 16'h0000;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cfg_r <= `CFG_DEFAULT;
            mode_r <= `MM_DEFAULT;
            rst_state_r <= RST_IDLE;
            rst_cnt_r <= 4'h0;
            soft_reset_r <= 1'b0;
            reg_rdata_r <= 16'h0000;
            reg_rvalid_r <= 1'b0;
        end else begin
            cfg_r <= cfg_nxt;
            mode_r <= mode_nxt;
            rst_state_r <= rst_state_nxt;
            rst_cnt_r <= rst_cnt_nxt;
            soft_reset_r <= soft_reset_nxt;
            reg_rdata_r <= reg_rd ? rdata_nxt : 16'h0000;
            reg_rvalid_r <= reg_rd;
        end
    end

    // ----------------------------------------
    // Channel selection
    // ----------------------------------------
    phase3_type volt_g;
    phase3_type curr_g;
    phase3_type volt_nxt;
    phase3_type curr_nxt;
    logic [`SAMPLE_W-1:0] neutral_nxt;
    phase3_type pv_nxt;
    logic [`SAMPLE_W-1:0] per_nxt;
    logic pin_nxt;

    always_comb begin
        curr_g = cfg_r[`CFG_INTEG] ? current_int : current_raw;
        neutral_nxt = cfg_r[`CFG_INTEG] ? neutral_int : neutral_raw;
        volt_g = voltage_raw;
        if (cfg_r[`CFG_VGND]) begin
            volt_g = '0;
        end
        if (cfg_r[`CFG_IGND]) begin
            curr_g = '0;
            neutral_nxt = '0;
        end
        volt_nxt = cfg_r[`CFG_SWAP] ? curr_g : volt_g;
        curr_nxt = cfg_r[`CFG_SWAP] ? volt_g : curr_g;
        pin_nxt = cfg_r[`CFG_FAST] ? fast_capture_clock : energy_pulse;
    end

    phase_voltage_mux u_mux_a (
        .code(cfg_r[`CFG_VA_LSB +: 2]),
        .base(`PHASE_A),
        .volts(volt_nxt),
        .chosen(pv_nxt.a)
    );

    phase_voltage_mux u_mux_b (
        .code(cfg_r[`CFG_VB_LSB +: 2]),
        .base(`PHASE_B),
        .volts(volt_nxt),
        .chosen(pv_nxt.b)
    );

    phase_voltage_mux u_mux_c (
        .code(cfg_r[`CFG_VC_LSB +: 2]),
        .base(`PHASE_C),
        .volts(volt_nxt),
        .chosen(pv_nxt.c)
    );

    phase_voltage_mux u_mux_per (
        .code(mode_r[`MM_PER_LSB +: 2]),
        .base(`PHASE_A),
        .volts(volt_nxt),
        .chosen(per_nxt)
    );

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            voltage_out_r <= '0;
            current_out_r <= '0;
            neutral_out_r <= '0;
            power_voltage_r <= '0;
            period_voltage_r <= '0;
            third_pulse_pin_r <= 1'b0;
            fast_capture_port_enable_r <= 1'b0;
        end else begin
            voltage_out_r <= volt_nxt;
            current_out_r <= curr_nxt;
            neutral_out_r <= neutral_nxt;
            power_voltage_r <= pv_nxt;
            period_voltage_r <= per_nxt;
            third_pulse_pin_r <= pin_nxt;
            fast_capture_port_enable_r <= cfg_r[`CFG_FAST];
        end
    end

    // ----------------------------------------
    // Peak window counting
    // ----------------------------------------
    logic [2:0] zc_en;
    logic [1:0] zc_count;
    logic [8:0] win_sum;
    logic [7:0] win_cnt_r;
    logic [7:0] win_cnt_nxt;
    logic win_done_nxt;

    function automatic logic [1:0] ones3(input logic [2:0] v);
        ones3 = {1'b0, v[0]} + {1'b0, v[1]} + {1'b0, v[2]};
    endfunction

    always_comb begin
        zc_en = zero_cross & mode_r[`MM_PEAK_LSB +: 3];
        zc_count = ones3(zc_en);
        win_sum = {1'b0, win_cnt_r} + {7'h00, zc_count};
        win_done_nxt = 1'b0;
        win_cnt_nxt = win_sum[7:0];
        if (zc_count != 2'h0 && win_sum >= {1'b0, peak_window_cycles}) begin
            win_done_nxt = 1'b1;
            win_cnt_nxt = 8'h00;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            win_cnt_r <= 8'h00;
            peak_window_done_r <= 1'b0;
            peak_phase_enables_r <= 3'h7;
        end else begin
            win_cnt_r <= win_cnt_nxt;
            peak_window_done_r <= win_done_nxt;
            peak_phase_enables_r <= mode_r[`MM_PEAK_LSB +: 3];
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    integ_select_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (cfg_r[`CFG_INTEG] && !cfg_r[`CFG_IGND]) |=> neutral_out_r == $past(neutral_int))
        else $error("Neutral current did not follow the integrator path.");

    swap_paths_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (cfg_r[`CFG_SWAP] && !cfg_r[`CFG_VGND]) |=> current_out_r == $past(voltage_raw))
        else $error("Swapped current outputs do not carry voltage data.");

    volt_ground_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (cfg_r[`CFG_VGND] && !cfg_r[`CFG_SWAP]) |=> voltage_out_r == '0)
        else $error("Grounded voltage channel shows nonzero data.");

    curr_ground_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (cfg_r[`CFG_IGND] && !cfg_r[`CFG_SWAP]) |=> current_out_r == '0 && neutral_out_r == '0)
        else $error("Grounded current channel shows nonzero data.");

    pin_share_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ##1 third_pulse_pin_r == ($past(cfg_r[`CFG_FAST]) ? $past(fast_capture_clock)
                                                         : $past(energy_pulse)))
        else $error("Shared pin carries the wrong source.");

    reset_start_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (reg_wr && reg_addr == `CFG_ADDR && reg_wdata[`CFG_SOFT_RST] && !soft_reset_r)
        |=> soft_reset_r [*4] ##1 !soft_reset_r)
        else $error("Software reset pulse has the wrong length.");

    reset_defaults_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $fell(soft_reset_r) |-> cfg_r == `CFG_DEFAULT && mode_r == `MM_DEFAULT)
        else $error("Registers not at defaults after software reset.");

    phase_a_pair_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (cfg_r[`CFG_VA_LSB +: 2] == 2'h1) |=> power_voltage_r.a == $past(volt_nxt.b))
        else $error("Phase A current paired with the wrong voltage.");

    phase_c_pair_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (cfg_r[`CFG_VC_LSB +: 2] == `SEL_RESERVED) |=> power_voltage_r.c == $past(volt_nxt.c))
        else $error("Reserved code for phase C did not act as the default.");

    period_pick_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (mode_r[`MM_PER_LSB +: 2] == 2'h2) |=> period_voltage_r == $past(volt_nxt.c))
        else $error("Period measurement uses the wrong phase.");

    reserved_zero_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (reg_rvalid_r && $past(reg_addr) == `CFG_ADDR)
        |-> reg_rdata_r[15:14] == 2'h0 && reg_rdata_r[2:1] == 2'h0)
        else $error("Reserved bits read back nonzero.");

    mode_reserved_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (reg_rvalid_r && $past(reg_addr) == `MODE_ADDR) |-> reg_rdata_r[15:5] == 11'h000)
        else $error("Reserved mode bits read back nonzero.");

    phase_b_pair_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (cfg_r[`CFG_VB_LSB +: 2] == 2'h2) |=> power_voltage_r.b == $past(volt_nxt.a))
        else $error("Phase B current paired with the wrong voltage.");

    peak_enable_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ##1 peak_phase_enables_r == $past(mode_r[`MM_PEAK_LSB +: 3]))
        else $error("Peak phase enables do not follow the mode register.");

    reset_bit_clear_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        cfg_r[`CFG_SOFT_RST] == soft_reset_r)
        else $error("Software reset bit does not track the running reset.");

    write_block_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (soft_reset_r && reg_wr && rst_cnt_r != 4'h1)
        |=> cfg_r == $past(cfg_r) && mode_r == $past(mode_r))
        else $error("Register write landed during a software reset.");

    peak_count_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (zc_count == 2'h0) |=> win_cnt_r == $past(win_cnt_r) && !peak_window_done_r)
        else $error("Peak window advanced without an enabled crossing.");

endmodule

// >>> verification/metering_config_select_bench.sv
// Purpose: Self-checking bench for the metering configuration and selection bank.
// Assumes: Register reads answer one cycle after the strobe; datapath outputs lag one cycle.
// Notes: A bench model of both registers predicts every output checked in run_cycles.
`timescale 1ns/1ps
`include "metering_config_params.svh"
module metering_config_select_bench
    import metering_config_pkg::*;
;
    logic clk_sys;
    logic sys_rst;
    logic [15:0] reg_addr;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata_r;
    logic reg_rvalid_r;
    phase3_type voltage_raw, current_raw, current_int, voltage_out_r, current_out_r;
    phase3_type power_voltage_r, pv, pc, pci;
    logic [`SAMPLE_W-1:0] neutral_raw, neutral_int, neutral_out_r, period_voltage_r, pnr, pni;
    logic [2:0] zero_cross;
    logic [2:0] pzc;
    logic [7:0] peak_window_cycles;
    logic [2:0] peak_phase_enables_r;
    logic peak_window_done_r, energy_pulse, fast_capture_clock, third_pulse_pin_r;
    logic fast_capture_port_enable_r, soft_reset_r, pep, pfc;
    int bad_count = 0;
    int n_checks = 0;
    int cycle_count = 0;
    int pk_cnt = 0;
    logic [31:0] seed;
    logic [31:0] t;
    logic [15:0] cfg_m;
    logic [7:0] mm_m;

    metering_config_select u_dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
        .reg_rvalid_r(reg_rvalid_r), .voltage_raw(voltage_raw), .current_raw(current_raw),
        .current_int(current_int), .neutral_raw(neutral_raw), .neutral_int(neutral_int),
        .voltage_out_r(voltage_out_r), .current_out_r(current_out_r),
        .neutral_out_r(neutral_out_r), .power_voltage_r(power_voltage_r),
        .period_voltage_r(period_voltage_r), .zero_cross(zero_cross),
        .peak_window_cycles(peak_window_cycles), .peak_phase_enables_r(peak_phase_enables_r),
        .peak_window_done_r(peak_window_done_r), .energy_pulse(energy_pulse),
        .fast_capture_clock(fast_capture_clock), .third_pulse_pin_r(third_pulse_pin_r),
        .fast_capture_port_enable_r(fast_capture_port_enable_r), .soft_reset_r(soft_reset_r)
    );

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // --------------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [`SAMPLE_W-1:0] r24();
        logic [31:0] v;
        v = rnd();
        return v[`SAMPLE_W-1:0];
    endfunction

    // Code 3 falls back to the base phase; other codes count on from it.
    function automatic logic [`SAMPLE_W-1:0] pick(phase3_type p, int code, int base);
        int idx;
        idx = (code == 3) ? base : (base + code) % 3;
        return (idx == 0) ? p.a : ((idx == 1) ? p.b : p.c);
    endfunction

    task automatic check(input logic ok, input string what);
        n_checks++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("BAD %0t %s", $time, what);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        check(reg_rvalid_r === 1'b1 && reg_rdata_r === exp, "register read");
    endtask

    // Drives fresh samples every edge and checks the previous edge's result.
    task automatic run_cycles(input int n);
        phase3_type vo, co, vg, cg, pw;
        logic [`SAMPLE_W-1:0] ng, rv;
        int newc;
        logic done_x;
        for (int i = 0; i <= n; i++) begin
            @(posedge clk_sys);
            rv = r24();
            voltage_raw <= {r24(), r24(), r24()};
            current_raw <= {r24(), r24(), r24()};
            current_int <= {r24(), r24(), r24()};
            neutral_raw <= r24();
            neutral_int <= r24();
            energy_pulse <= rv[0];
            fast_capture_clock <= rv[1];
            zero_cross <= (i < n) ? rv[4:2] : 3'h0;
            @(negedge clk_sys);
            if (i > 0) begin
                cg = cfg_m[0] ? pci : pc;
                ng = cfg_m[0] ? pni : pnr;
                vg = cfg_m[4] ? '0 : pv;
                if (cfg_m[5]) begin
                    cg = '0;
                    ng = '0;
                end
                vo = cfg_m[3] ? cg : vg;
                co = cfg_m[3] ? vg : cg;
                pw.a = pick(vo, cfg_m[9:8], 0);
                pw.b = pick(vo, cfg_m[11:10], 1);
                pw.c = pick(vo, cfg_m[13:12], 2);
                newc = $countones(pzc & mm_m[4:2]);
                done_x = newc != 0 && (pk_cnt + newc) >= peak_window_cycles;
                pk_cnt = done_x ? 0 : pk_cnt + newc;
                check(voltage_out_r === vo, "voltage channel");
                check(current_out_r === co && neutral_out_r === ng, "current channel");
                check(power_voltage_r === pw, "power pairing");
                check(period_voltage_r === pick(vo, mm_m[1:0], 0), "period phase");
                check(third_pulse_pin_r === (cfg_m[6] ? pfc : pep), "shared pin");
                check(fast_capture_port_enable_r === cfg_m[6], "port enable");
                check(peak_phase_enables_r === mm_m[4:2], "peak enables");
                check(peak_window_done_r === done_x, "peak window");
            end
            pv = voltage_raw;
            pc = current_raw;
            pci = current_int;
            pnr = neutral_raw;
            pni = neutral_int;
            pzc = zero_cross;
            pep = energy_pulse;
            pfc = fast_capture_clock;
        end
    endtask

    // --------------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------------
    initial begin
        seed = 32'h7B86B258;
        cfg_m = `CFG_DEFAULT;
        mm_m = `MM_DEFAULT;
        sys_rst <= 1'b1;
        reg_addr <= 16'h0000;
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        reg_wdata <= 16'h0000;
        voltage_raw <= '0;
        current_raw <= '0;
        current_int <= '0;
        neutral_raw <= '0;
        neutral_int <= '0;
        zero_cross <= 3'h0;
        peak_window_cycles <= 8'h05;
        energy_pulse <= 1'b0;
        fast_capture_clock <= 1'b0;
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(negedge clk_sys);
        check(peak_phase_enables_r === 3'h7 && soft_reset_r === 1'b0, "reset state");
        rd(`CFG_ADDR, `CFG_DEFAULT);
        rd(`MODE_ADDR, 16'h001C);
        rd(16'hE619, 16'h0000);
        wr(`MODE_ADDR, 16'h0003);
        wr(`CFG_ADDR, 16'h3FF9);
        for (int k = 0; k < 6; k++) begin
            @(negedge clk_sys);
            check(soft_reset_r === (k < 4), "soft reset length");
        end
        // A write that arrives while a software reset runs is ignored.
        wr(`CFG_ADDR, 16'h0080);
        wr(`CFG_ADDR, 16'h0001);
        rd(`CFG_ADDR, 16'h0080);
        rd(`CFG_ADDR, `CFG_DEFAULT);
        rd(`MODE_ADDR, 16'h001C);
        // Each pass sets the four select fields to four different codes; over the eight passes each field steps through all four codes twice.
        for (int i = 0; i < 8; i++) begin
            t = rnd();
            cfg_m = (t[15:0] & 16'hC07F) | {2'h0, 2'(i + 2), 2'(i + 1), 2'(i), 8'h00};
            mm_m = {t[23:18], 2'(i + 3)};
            wr(`CFG_ADDR, cfg_m);
            wr(`MODE_ADDR, {t[31:24], mm_m});
            cfg_m = cfg_m & 16'h3F79;
            mm_m = mm_m & `MM_WMASK;
            rd(`CFG_ADDR, cfg_m);
            rd(`MODE_ADDR, {8'h00, mm_m});
            @(posedge clk_sys);
            peak_window_cycles <= 8'(i);
            run_cycles(24);
        end
        complete_run();
    end

    always @(posedge clk_sys) begin
        cycle_count++;
        if (cycle_count >= 5000) begin
            bad_count++;
            complete_run();
        end
    end
endmodule
